//--- core/stsp_defines.vh
// Constants of the stepper telegram port: word layout, status layout, counts.
// Included by stsp_ocp_counter and stsp_top (not stsp_sync); holds definitions only.
`ifndef STSP_DEFINES_VH
`define STSP_DEFINES_VH

// ----------------------------------------------------------------
// Word sizes
// ----------------------------------------------------------------
`define STSP_WORD_W 12
`define STSP_CNT_W 4
`define STSP_WORD_DONE 4'hc
`define STSP_WORD_OVER 4'hd

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define STSP_CMD_MDA 11
`define STSP_CMD_CA_MSB 10
`define STSP_CMD_CA_LSB 7
`define STSP_CMD_PHA 6
`define STSP_CMD_MDB 5
`define STSP_CMD_CB_MSB 4
`define STSP_CMD_CB_LSB 1
`define STSP_CMD_PHB 0
`define STSP_CODE_ZERO 4'h0

// ----------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------
`define STSP_ST_LD_MSB 11
`define STSP_ST_LD_LSB 9
`define STSP_ST_ONE 8
`define STSP_ST_OT 7
`define STSP_ST_TEMP_PREWARN_FLAG 6
`define STSP_ST_UV 5
`define STSP_ST_OVERCURRENT_HIGH_SIDE_FLAG 4
`define STSP_ST_OLB 3
`define STSP_ST_OLA 2
`define STSP_ST_OCB 1
`define STSP_ST_OCA 0

// ----------------------------------------------------------------
// Reset values and protection counts
// ----------------------------------------------------------------
`define STSP_CMD_RESET 12'h000
`define STSP_OC_LIMIT 3
`define STSP_OC_WINDOW 63
`define STSP_OL_CYCLES 14

`endif

//--- core/stsp_ocp_counter.v
// Overcurrent error counter for one comparator (a low side or the high side).
// Assumes pwm_tick marks the end of each PWM cycle and oc_event is on clk_sys.
`timescale 1ns/1ps
`include "stsp_defines.vh"

module stsp_ocp_counter #(
  parameter LIMIT = `STSP_OC_LIMIT,
  parameter WINDOW = `STSP_OC_WINDOW
) (
  input wire clk_sys,
  input wire rst,
  input wire clear,
  input wire pwm_tick,
  input wire oc_event,
  output reg flag_q,
  output reg bridge_off_q
);

  reg [1:0] err_q;
  reg [6:0] quiet_q;
  reg [6:0] off_q;
  reg seen_q;
  wire seen_now;
  wire hit;

  assign seen_now = seen_q | oc_event;
  assign hit = pwm_tick & seen_now & (err_q == LIMIT[1:0] - 2'h1);

  // ----------------------------------------------------------------
  // Count overcurrent cycles, forget them after a quiet window
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      err_q <= 2'h0;
      quiet_q <= 7'h00;
      off_q <= 7'h00;
      seen_q <= 1'b0;
      flag_q <= 1'b0;
      bridge_off_q <= 1'b0;
    end
    else
    begin
      seen_q <= pwm_tick ? 1'b0 : seen_now;
      if (hit)
      begin
        // Set wins over a clear arriving in the same cycle
        err_q <= 2'h0;
        quiet_q <= 7'h00;
        off_q <= WINDOW[6:0]; // see R13
        flag_q <= 1'b1; // see R13
        bridge_off_q <= 1'b1;
      end
      else if (clear)
      begin
        err_q <= 2'h0;
        quiet_q <= 7'h00;
        off_q <= 7'h00;
        flag_q <= 1'b0;
        bridge_off_q <= 1'b0;
      end
      else if (pwm_tick)
      begin
        if (seen_now)
        begin
          err_q <= err_q + 2'h1;
          quiet_q <= 7'h00;
        end
        else if (quiet_q >= WINDOW[6:0])
        begin
          err_q <= 2'h0;
        end
        else
        begin
          quiet_q <= quiet_q + 7'h01;
        end
        if (off_q != 7'h00)
        begin
          off_q <= off_q - 7'h01;
        end
        bridge_off_q <= (off_q > 7'h01);
      end
    end
  end

endmodule // stsp_ocp_counter

//--- core/stsp_sync.v
// Two-stage synchroniser for levels arriving from outside clk_sys.
// Assumes the inputs are slow against clk_sys; no glitch filtering here.
`timescale 1ns/1ps

module stsp_sync #(
  parameter W = 1
) (
  input wire clk_sys,
  input wire rst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_q;

  // ----------------------------------------------------------------
  // Stage one is read only by stage two
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // stsp_sync

//--- core/stsp_top.v
// Serial telegram port of a dual full-bridge stepper driver.
// Assumes the master clocks data in on the rising serial clock edge and
// out on the falling one, and that all pin levels are slow against clk_sys.
// Operation
// R01: Command and status words are both twelve bits, shifted most significant first.
// R02: Command bit 11 selects mixed decay for bridge A.
// R03: Command bits 10..7 are the bridge A current code, bit 10 highest.
// R04: Command bit 6 is bridge A polarity; zero drives first toward second output.
// R05: Command bit 5 selects mixed decay for bridge B.
// R06: Command bits 4..1 are the bridge B current code, bit 4 highest.
// R07: Command bit 0 is bridge B polarity; zero drives first toward second output.
// R08: Current code zero gives no current and holds the bridge in slow decay.
// R09: Current code is linear; all ones is full scale, fifteen sixteenths.
// R10: The controller sends one full telegram per microstep, sine and cosine.
// R11: Status bits 11..9 carry the three-bit load level, bit 11 highest.
// R12: Status bits 7, 6, 5 report overtemperature off, prewarning, supply low.
// R13: Status bits 4, 1, 0 flag overcurrent after 3 in 63 PWM cycles.
// R14: Status bits 3, 2 flag open load after 14 oscillator cycles unswitched.
// R15: All port registers clear on reset and while the enable pin is high; use_external_ref still follows the select pins while enable is high.
// R16: The serial port only works while the serial mode select is high.
// R17: The enable pin is active low and also acts as overvoltage shutdown.
// R18: The serial data output is tri-state and releases the line.
// R19: Analog reference select low scales currents by the external references; use_external_ref stays low while the serial mode select is low.
// R20: Both codes zero clears overcurrent flags and enters low-current standby.
// R21: Open load of a bridge with code zero always reads zero.
// R22: The reported load level is refreshed once per fullstep.
// R23: Status bit 8 always reads one.
// R24: Chip select frames a telegram; a complete word applies at its release.
// R25: Status is captured at telegram start; output is driven only while selected.
`timescale 1ns/1ps
`include "stsp_defines.vh"

module stsp_top #(
  parameter OL_CYCLES = `STSP_OL_CYCLES
) (
  input wire clk_sys,
  input wire rst,
  input wire sck,
  input wire sdi,
  input wire chip_select_low,
  input wire device_enable_low,
  input wire serial_mode_select,
  input wire analog_ref_select_low,
  output reg sdo_o,
  output reg sdo_oe,
  input wire sdo_i,
  input wire [2:0] load_level,
  input wire load_fullstep,
  input wire overtemp_off_flag,
  input wire temp_prewarn_flag,
  input wire supply_low_flag,
  input wire pwm_tick,
  input wire osc_tick,
  input wire oc_low_a_event,
  input wire oc_low_b_event,
  input wire oc_high_event,
  input wire pwm_off_a,
  input wire pwm_off_b,
  output reg mixed_decay_a,
  output reg [3:0] coil_a_current_code,
  output reg polarity_a,
  output reg slow_decay_hold_a,
  output reg bridge_a_off,
  output reg mixed_decay_b,
  output reg [3:0] coil_b_current_code,
  output reg polarity_b,
  output reg slow_decay_hold_b,
  output reg bridge_b_off,
  output reg low_current_standby,
  output reg use_external_ref
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire sck_s;
  wire sdi_s;
  wire csn_s;
  wire enn_s;
  wire spe_s;
  wire ann_s;

  stsp_sync #(
    .W(6)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({sck, sdi, chip_select_low, device_enable_low, serial_mode_select,
        analog_ref_select_low}),
    .q({sck_s, sdi_s, csn_s, enn_s, spe_s, ann_s})
  );

  // ----------------------------------------------------------------
  // Edge detection on synchronised levels
  // ----------------------------------------------------------------
  reg sck_prev_q;
  reg csn_prev_q;
  wire port_off;
  wire sel;
  wire sck_rise;
  wire sck_fall;
  wire csn_fall;
  wire csn_rise;

  // A high enable pin doubles as overvoltage shutdown and holds the port cleared
  assign port_off = enn_s | ~spe_s; // see R15 // see R16 // see R17
  assign sel = ~csn_s;
  assign sck_rise = sel & sck_s & ~sck_prev_q;
  assign sck_fall = sel & ~sck_s & sck_prev_q;
  assign csn_fall = ~csn_s & csn_prev_q;
  assign csn_rise = csn_s & ~csn_prev_q;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      sck_prev_q <= 1'b0;
      csn_prev_q <= 1'b1;
    end
    else
    begin
      sck_prev_q <= sck_s;
      csn_prev_q <= csn_s;
    end
  end

  // ----------------------------------------------------------------
  // Status assembly
  // ----------------------------------------------------------------
  reg [2:0] load_q;
  wire [1:0] ol_flag;
  wire [2:0] oc_flag;
  wire [2:0] oc_off;
  wire [11:0] status;

  always @(posedge clk_sys)
  begin
    if (rst || port_off)
    begin
      load_q <= 3'h0;
    end
    else if (load_fullstep)
    begin
      load_q <= load_level; // see R22
    end
  end

  assign status[`STSP_ST_LD_MSB:`STSP_ST_LD_LSB] = load_q; // see R11
  assign status[`STSP_ST_ONE] = 1'b1; // see R23
  assign status[`STSP_ST_OT] = overtemp_off_flag; // see R12
  assign status[`STSP_ST_TEMP_PREWARN_FLAG] = temp_prewarn_flag; // see R12
  assign status[`STSP_ST_UV] = supply_low_flag; // see R12
  assign status[`STSP_ST_OVERCURRENT_HIGH_SIDE_FLAG] = oc_flag[2]; // see R13
  assign status[`STSP_ST_OLB] = ol_flag[1]; // see R14
  assign status[`STSP_ST_OLA] = ol_flag[0]; // see R14
  assign status[`STSP_ST_OCB] = oc_flag[1]; // see R13
  assign status[`STSP_ST_OCA] = oc_flag[0]; // see R13

  // ----------------------------------------------------------------
  // Serial shifter
  // ----------------------------------------------------------------
  reg [11:0] rx_q;
  reg [11:0] tx_q;
  reg [3:0] cnt_q;
  reg zero_clr_q;

  always @(posedge clk_sys)
  begin
    if (rst || port_off)
    begin
      rx_q <= `STSP_CMD_RESET;
      tx_q <= `STSP_CMD_RESET;
      cnt_q <= 4'h0;
      sdo_o <= 1'b0;
      sdo_oe <= 1'b0;
    end
    else
    begin
      sdo_oe <= sel; // see R18 // see R25
      if (csn_fall)
      begin
        // Snapshot keeps the word stable while it shifts out
        sdo_o <= status[`STSP_WORD_W-1]; // see R25 // see R01
        tx_q <= {status[`STSP_WORD_W-2:0], 1'b0};
        cnt_q <= 4'h0;
      end
      else if (sck_rise)
      begin
        rx_q <= {rx_q[`STSP_WORD_W-2:0], sdi_s}; // see R01
        if (cnt_q != `STSP_WORD_OVER)
        begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
      else if (sck_fall)
      begin
        sdo_o <= tx_q[`STSP_WORD_W-1]; // see R01
        tx_q <= {tx_q[`STSP_WORD_W-2:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Command application at end of frame
  // ----------------------------------------------------------------
  wire [3:0] code_a_rx;
  wire [3:0] code_b_rx;
  wire frame_ok;
  wire both_zero;

  assign code_a_rx = rx_q[`STSP_CMD_CA_MSB:`STSP_CMD_CA_LSB]; // see R03
  assign code_b_rx = rx_q[`STSP_CMD_CB_MSB:`STSP_CMD_CB_LSB]; // see R06
  // A short or long frame is dropped whole so a glitch cannot move a coil
  assign frame_ok = csn_rise & (cnt_q == `STSP_WORD_DONE); // see R24
  assign both_zero = (code_a_rx == `STSP_CODE_ZERO) & (code_b_rx == `STSP_CODE_ZERO);

  always @(posedge clk_sys)
  begin
    if (rst || port_off)
    begin
      mixed_decay_a <= 1'b0;
      coil_a_current_code <= 4'h0;
      polarity_a <= 1'b0;
      mixed_decay_b <= 1'b0;
      coil_b_current_code <= 4'h0;
      polarity_b <= 1'b0;
      low_current_standby <= 1'b0;
      zero_clr_q <= 1'b0;
    end
    else
    begin
      zero_clr_q <= frame_ok & both_zero; // see R20
      if (frame_ok)
      begin
        mixed_decay_a <= rx_q[`STSP_CMD_MDA]; // see R02
        coil_a_current_code <= code_a_rx; // see R03 // see R09
        polarity_a <= rx_q[`STSP_CMD_PHA]; // see R04
        mixed_decay_b <= rx_q[`STSP_CMD_MDB]; // see R05
        coil_b_current_code <= code_b_rx; // see R06 // see R09
        polarity_b <= rx_q[`STSP_CMD_PHB]; // see R07
        low_current_standby <= both_zero; // see R20
      end
    end
  end

  // ----------------------------------------------------------------
  // Overcurrent counters
  // ----------------------------------------------------------------
  wire oc_clear;
  wire [2:0] oc_ev;

  assign oc_clear = port_off | zero_clr_q; // see R20 // see R15
  // Slot 0 is bridge A low side, slot 1 bridge B low side, slot 2 the high side
  assign oc_ev = {oc_high_event, oc_low_b_event, oc_low_a_event}; // see R13

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_oc
      stsp_ocp_counter u_oc (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear(oc_clear),
        .pwm_tick(pwm_tick),
        .oc_event(oc_ev[gi]),
        .flag_q(oc_flag[gi]),
        .bridge_off_q(oc_off[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Open load watchdogs, one per bridge
  // ----------------------------------------------------------------
  wire [1:0] sw_off;
  wire [1:0] code_zero;

  assign sw_off = {pwm_off_b, pwm_off_a};
  assign code_zero = {coil_b_current_code == `STSP_CODE_ZERO,
                      coil_a_current_code == `STSP_CODE_ZERO};

  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_ol
      reg [4:0] run_q;
      reg flag_q;
      assign ol_flag[gi] = flag_q;
      always @(posedge clk_sys)
      begin
        // Chopper idle at code zero, and a switch-off restarts the watch
        if (rst || port_off || code_zero[gi] || sw_off[gi])
        begin
          run_q <= 5'h00;
          flag_q <= 1'b0; // see R21
        end
        else if (osc_tick)
        begin
          if (run_q != OL_CYCLES[4:0])
          begin
            run_q <= run_q + 5'h01;
          end
          else
          begin
            flag_q <= 1'b1; // see R14
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bridge controls
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      slow_decay_hold_a <= 1'b1;
      slow_decay_hold_b <= 1'b1;
      bridge_a_off <= 1'b1;
      bridge_b_off <= 1'b1;
      use_external_ref <= 1'b0;
    end
    else
    begin
      slow_decay_hold_a <= code_zero[0]; // see R08
      slow_decay_hold_b <= code_zero[1]; // see R08
      // High side fault cannot be located, so both bridges stop
      bridge_a_off <= port_off | oc_off[0] | oc_off[2];
      bridge_b_off <= port_off | oc_off[1] | oc_off[2];
      use_external_ref <= spe_s & ~ann_s; // see R19
    end
  end

endmodule // stsp_top

//--- sim/stsp_master.sv
// Motion controller model: serial master, idle-low clock, 400 ns period.
// Assumes clk_sys at 50 ns; the slave shifts out after each falling edge.
`timescale 1ns/1ps

module stsp_master (
  input wire clk_sys,
  input wire sdo,
  output logic sck,
  output logic sdi,
  output logic chip_select_low
);
  // --------
  // Frames
  // --------
  initial
  begin
    sck = 1'b0;
    sdi = 1'b0;
    chip_select_low = 1'b1;
  end

  // Clock high 3 cycles, low 5: slave output needs 3 cycles to settle
  task automatic xfer(input logic [11:0] w, input int n, output logic [11:0] r);
    logic [11:0] sh;
    sh = w;
    r = 12'h000;
    @(posedge clk_sys);
    chip_select_low <= 1'b0;
    sdi <= sh[11];
    repeat (3) @(posedge clk_sys);
    repeat (n)
    begin
      repeat (3) @(posedge clk_sys);
      sck <= 1'b1;
      r = {r[10:0], sdo};
      repeat (3) @(posedge clk_sys);
      sck <= 1'b0;
      repeat (2) @(posedge clk_sys);
      sh = sh << 1;
      sdi <= sh[11];
    end
    repeat (4) @(posedge clk_sys);
    chip_select_low <= 1'b1;
    sdi <= ~sdi;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule // stsp_master

//--- sim/stsp_monitor.sv
// Port checks of the stepper telegram port, bound into stsp_top.
// Assumes one clock domain, clk_sys, and the synchronous reset rst.
`timescale 1ns/1ps

module stsp_monitor (
  input wire clk_sys,
  input wire rst,
  input wire chip_select_low,
  input wire device_enable_low,
  input wire serial_mode_select,
  input wire analog_ref_select_low,
  input wire sdo_oe,
  input wire mixed_decay_a,
  input wire [3:0] coil_a_current_code,
  input wire polarity_a,
  input wire slow_decay_hold_a,
  input wire bridge_a_off,
  input wire mixed_decay_b,
  input wire [3:0] coil_b_current_code,
  input wire polarity_b,
  input wire slow_decay_hold_b,
  input wire bridge_b_off,
  input wire low_current_standby,
  input wire use_external_ref
);
  // --------
  // Helpers
  // --------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [3:0] clr_h;
  wire [11:0] cmd = {mixed_decay_a, coil_a_current_code, polarity_a,
                     mixed_decay_b, coil_b_current_code, polarity_b};
  wire ext_c = serial_mode_select & ~analog_ref_select_low;

  // Recent held clear, so a clear is not taken for a stray update
  always @(posedge clk_sys)
  begin
    if (rst)
      clr_h <= 4'h0;
    else
      clr_h <= {clr_h[2:0], device_enable_low | ~serial_mode_select};
  end

  sequence s_cs_fall;
    chip_select_low ##1 !chip_select_low;
  endsequence

  // --------
  // Checks
  // --------
  a_oe_follows_cs: assert property (
    s_cs_fall ##0 !clr_h[0] |-> ##[2:5] sdo_oe)
    else $error("sdo_oe did not rise after chip select");
  a_oe_needs_cs: assert property (
    $rose(sdo_oe) |-> !$past(chip_select_low, 2))
    else $error("sdo_oe rose while unselected");
  a_oe_released: assert property (
    chip_select_low [*5] |-> !sdo_oe)
    else $error("sdo_oe held while unselected");
  a_cmd_at_close: assert property (
    $changed(cmd) |-> (|clr_h) || ($past(chip_select_low, 3) && !$past(chip_select_low, 6)))
    else $error("command changed outside a frame close");
  a_standby_zero: assert property (
    $rose(low_current_standby) |-> cmd[10:7] == 4'h0 && cmd[4:1] == 4'h0)
    else $error("standby without two zero codes");
  a_hold_a_zero: assert property (
    $stable(coil_a_current_code) |-> slow_decay_hold_a == (coil_a_current_code == 4'h0))
    else $error("bridge A slow decay hold wrong");
  a_hold_b_zero: assert property (
    $stable(coil_b_current_code) |-> slow_decay_hold_b == (coil_b_current_code == 4'h0))
    else $error("bridge B slow decay hold wrong");
  a_ext_ref_sel: assert property (
    $stable(ext_c) [*5] |-> use_external_ref == ext_c)
    else $error("external reference select wrong");
  a_disabled_clear: assert property (
    device_enable_low [*5] |-> bridge_a_off && bridge_b_off && !sdo_oe && cmd == 12'h000)
    else $error("disabled port not cleared");
  a_serial_off: assert property (
    !serial_mode_select [*5] |-> !sdo_oe && cmd == 12'h000)
    else $error("serial port active with mode select low");
endmodule // stsp_monitor

bind stsp_top stsp_monitor u_mon (.clk_sys(clk_sys), .rst(rst),
  .chip_select_low(chip_select_low), .device_enable_low(device_enable_low),
  .serial_mode_select(serial_mode_select), .analog_ref_select_low(analog_ref_select_low),
  .sdo_oe(sdo_oe), .mixed_decay_a(mixed_decay_a), .coil_a_current_code(coil_a_current_code),
  .polarity_a(polarity_a), .slow_decay_hold_a(slow_decay_hold_a), .bridge_a_off(bridge_a_off),
  .mixed_decay_b(mixed_decay_b), .coil_b_current_code(coil_b_current_code),
  .polarity_b(polarity_b), .slow_decay_hold_b(slow_decay_hold_b), .bridge_b_off(bridge_b_off),
  .low_current_standby(low_current_standby), .use_external_ref(use_external_ref));

//--- sim/stsp_top_tb.sv
// Self-checking bench of the stepper telegram port.
// Assumes the master model and the bound checker; open load count set to 3.
`timescale 1ns/1ps

module stsp_top_tb;
  // --------
  // Wiring
  // --------
  localparam logic [11:0] TBL [8] = '{12'h800, 12'h780, 12'h040, 12'h020,
                                      12'h01e, 12'h001, 12'hfff, 12'h5a5};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic device_enable_low = 1'b0;
  logic serial_mode_select = 1'b1;
  logic analog_ref_select_low = 1'b1;
  logic [2:0] load_level = 3'h0;
  logic [2:0] flags = 3'h0;
  logic [7:0] ev = 8'h00;
  logic [11:0] r;
  int err_total = 0;
  int total_checks = 0;
  wire sck, sdi, chip_select_low, sdo_o, sdo_oe;
  wire mixed_decay_a, polarity_a, slow_decay_hold_a, bridge_a_off;
  wire mixed_decay_b, polarity_b, slow_decay_hold_b, bridge_b_off;
  wire low_current_standby, use_external_ref;
  wire [3:0] coil_a_current_code, coil_b_current_code;
  wire sdo_w = sdo_oe ? sdo_o : 1'bz;
  wire [11:0] cmd = {mixed_decay_a, coil_a_current_code, polarity_a,
                     mixed_decay_b, coil_b_current_code, polarity_b};

  always #25 clk_sys = ~clk_sys;

  stsp_master mst (.clk_sys(clk_sys), .sdo(sdo_w), .sck(sck), .sdi(sdi),
    .chip_select_low(chip_select_low));

  stsp_top #(.OL_CYCLES(3)) dut (.clk_sys(clk_sys), .rst(rst), .sck(sck), .sdi(sdi),
    .chip_select_low(chip_select_low), .device_enable_low(device_enable_low),
    .serial_mode_select(serial_mode_select), .analog_ref_select_low(analog_ref_select_low),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sdo_i(sdo_w), .load_level(load_level),
    .load_fullstep(ev[7]), .overtemp_off_flag(flags[2]), .temp_prewarn_flag(flags[1]),
    .supply_low_flag(flags[0]), .pwm_tick(ev[6]), .osc_tick(ev[5]),
    .oc_low_a_event(ev[4]), .oc_low_b_event(ev[3]), .oc_high_event(ev[2]),
    .pwm_off_a(ev[1]), .pwm_off_b(ev[0]), .mixed_decay_a(mixed_decay_a),
    .coil_a_current_code(coil_a_current_code), .polarity_a(polarity_a),
    .slow_decay_hold_a(slow_decay_hold_a), .bridge_a_off(bridge_a_off),
    .mixed_decay_b(mixed_decay_b), .coil_b_current_code(coil_b_current_code),
    .polarity_b(polarity_b), .slow_decay_hold_b(slow_decay_hold_b),
    .bridge_b_off(bridge_b_off), .low_current_standby(low_current_standby),
    .use_external_ref(use_external_ref));

  // --------
  // Helpers
  // --------
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One-cycle pulse on the event inputs
  task automatic pulse(input logic [7:0] m);
    @(posedge clk_sys) ev <= m;
    @(posedge clk_sys) ev <= 8'h00;
  endtask

  function automatic logic [11:0] stw(input logic [2:0] ld, input logic [4:0] p);
    return {ld, 1'b1, flags, p};
  endfunction

  // --------
  // Scenarios
  // --------
  task automatic t_fields;
    load_level <= 3'h5;
    flags <= 3'h5;
    pulse(8'h80);
    load_level <= 3'h2;
    for (int i = 0; i < 8; i++)
    begin
      mst.xfer(TBL[i], 12, r);
      chk(cmd, TBL[i]);
      chk(r, stw(3'h5, 5'h00));
      chk({10'h0, slow_decay_hold_a, slow_decay_hold_b},
          {10'h0, TBL[i][10:7] == 4'h0, TBL[i][4:1] == 4'h0});
    end
  endtask

  task automatic t_refuse;
    mst.xfer(12'h000, 11, r);
    chk(cmd, 12'h5a5);
    mst.xfer(12'h000, 13, r);
    chk(cmd, 12'h5a5);
    chk({11'h0, low_current_standby}, 12'h000);
  endtask

  task automatic t_open_load;
    mst.xfer(12'h080, 12, r);
    pulse(8'h02);
    repeat (3) pulse(8'h20);
    mst.xfer(12'h080, 12, r);
    chk(r, stw(3'h5, 5'h00));
    pulse(8'h20);
    mst.xfer(12'h080, 12, r);
    chk(r, stw(3'h5, 5'h04));
    pulse(8'h02);
    mst.xfer(12'h5a5, 12, r);
    chk(r, stw(3'h5, 5'h00));
  endtask

  task automatic t_overcurrent;
    flags <= 3'h2;
    for (int i = 0; i < 3; i++)
    begin
      pulse(8'h1c);
      pulse(8'h40);
      if (i == 1)
      begin
        mst.xfer(12'h5a5, 12, r);
        chk(r, stw(3'h5, 5'h00));
      end
    end
    // Flag lands one edge after the tick, the bridge control one edge later
    repeat (2) @(posedge clk_sys);
    chk({10'h0, bridge_a_off, bridge_b_off}, 12'h003);
    mst.xfer(12'h000, 12, r);
    chk(r, stw(3'h5, 5'h13));
    chk({11'h0, low_current_standby}, 12'h001);
    mst.xfer(12'h5a5, 12, r);
    chk(r, stw(3'h5, 5'h00));
  endtask

  task automatic t_disable;
    mst.xfer(12'hfff, 12, r);
    device_enable_low <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(cmd, 12'h000);
    chk({10'h0, bridge_a_off, bridge_b_off}, 12'h003);
    device_enable_low <= 1'b0;
    repeat (4) @(posedge clk_sys);
    mst.xfer(12'h5a5, 12, r);
    chk(r, stw(3'h0, 5'h00));
    serial_mode_select <= 1'b0;
    repeat (4) @(posedge clk_sys);
    mst.xfer(12'hfff, 12, r);
    chk(r, 12'hzzz);
    chk(cmd, 12'h000);
    serial_mode_select <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic t_ext_ref;
    analog_ref_select_low <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({11'h0, use_external_ref}, 12'h001);
    serial_mode_select <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({11'h0, use_external_ref}, 12'h000);
    serial_mode_select <= 1'b1;
    analog_ref_select_low <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk({11'h0, use_external_ref}, 12'h000);
  endtask

  // --------
  // Run
  // --------
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    finish_test;
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_fields;
    t_refuse;
    t_open_load;
    t_overcurrent;
    t_disable;
    t_ext_ref;
    finish_test;
  end
endmodule // stsp_top_tb
